// *** verilog/aux_regs_pkg.sv ***
// Constants shared by the ISA auxiliary register group
`default_nettype none
package aux_regs_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam int SEL_W = 3;
   localparam int INT_W = 2;
   // Register offsets on the five low system address lines
   localparam logic [4:0] OFS_EEPROM_PIN_CONTROL = 5'h10;
   localparam logic [4:0] OFS_EEPROM_SERIAL_DATA = 5'h11;
   localparam logic [4:0] OFS_IO_BASE_ADVANCE = 5'h12;
   localparam logic [4:0] OFS_JUMPERLESS_SETTING = 5'h13;
   localparam logic [4:0] OFS_RESERVED_FIRST = 5'h14;
   localparam logic [4:0] OFS_SOFT_RESET_FIRST = 5'h18;
   localparam int SOFT_RESET_PORTS = 8;
   // Field positions
   localparam int EEPROM_SHIFT_CLOCK_BIT = 6;
   localparam int EEPROM_SELECT_BIT = 5;
   localparam int EEPROM_SERIAL_IO_BIT = 7;
   localparam int INT_SEL_LSB = 6;
   localparam int BASE_SEL_LSB = 0;
   // Reset values
   localparam logic EEPROM_SHIFT_CLOCK_RST = 1'h0;
   localparam logic EEPROM_SELECT_RST = 1'h0;
   localparam logic EEPROM_SERIAL_IO_RST = 1'h0;
   localparam logic [2:0] BASE_SEL_RST = 3'h0;
   localparam logic [7:0] READ_DATA_RST = 8'h00;
   localparam logic [7:0] BASE_ADVANCE_READ_VALUE = 8'h00;
   // Length of the soft reset pulse sent to the rest of the controller
   localparam int SOFT_RESET_CYCLES = 4;
endpackage : aux_regs_pkg
`default_nettype wire

// *** verilog/pin_sync.sv ***
// Two-stage synchroniser for asynchronous pin inputs
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '0;
         sync_out <= '0;
      end else begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule : pin_sync
`default_nettype wire

// *** verilog/base_select_counter.sv ***
// Three-bit I/O base select code, advanced by qualifying reads
`default_nettype none
module base_select_counter (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic soft_clear,
   input wire logic load,
   input wire logic [2:0] load_value,
   input wire logic advance_req,
   input wire logic jumperless,
   input wire logic unlock,
   output logic [2:0] sel_ff
);
   logic advance_ok;

   // Only jumperless mode with the unlock bit set may advance the code
   assign advance_ok = advance_req & jumperless & unlock;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_ff <= aux_regs_pkg::BASE_SEL_RST;
      end else if (soft_clear) begin
         sel_ff <= aux_regs_pkg::BASE_SEL_RST;
      end else if (load) begin
         sel_ff <= load_value;
      end else if (advance_ok) begin
         // Wraps from 111 back to 000
         sel_ff <= sel_ff + 3'h1;
      end
   end
endmodule : base_select_counter
`default_nettype wire

// *** verilog/isa_aux_eeprom_iobase_regs.sv ***
// ISA auxiliary register group: EEPROM bit-bang port, base select, soft reset ports
`default_nettype none
// Operation
// - The group exists only in ISA mode and decodes on the five low address lines, bank select ignored.
// - Software toggles the shift clock bit and the clock pin follows each written value.
// - Writing one to the select bit asserts the EEPROM chip select, writing zero negates it.
// - Reading the serial data register returns the EEPROM data output level in bit 7.
// - Writing the serial data register drives the EEPROM data input to bit 7 of the data.
// - Control register reads and unused data register bits carry no defined value.
// - Each read of the base advance register increments the three-bit select code.
// - The data returned by a base advance read has no meaning.
// - The select code is readable in bits 2 to 0 of the jumperless setting register.
// - The read-triggered advance acts only in jumperless ISA mode.
// - The code counts 000 to 111 and the new value drives the active base decode.
// - With the unlock bit cleared, base advance reads leave the code unchanged.
// - A write to any of the eight reset ports acts as a hardware reset except for the EEPROM port.
module isa_aux_eeprom_iobase_regs (
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic ISA_MODE,
   input wire logic JUMPERLESS_MODE,
   input wire logic GROUP_SEL_N,
   input wire logic [4:0] SA,
   input wire logic IOR_N,
   input wire logic IOW_N,
   input wire logic [7:0] SD_IN,
   output logic [7:0] SD_OUT,
   output logic SD_OE,
   input wire logic IO_BASE_UNLOCK,
   input wire logic BOOT_LOAD,
   input wire logic [2:0] BOOT_BASE_SEL,
   input wire logic [1:0] BOOT_INT_SEL,
   output logic [2:0] BASE_SEL,
   output logic EE_SK,
   output logic EE_CS,
   output logic EE_DI,
   input wire logic EE_DO,
   output logic SOFT_RESET
);
   localparam int PIN_W = 1 + 1 + 1 + 5 + 1 + 1 + 8 + 1;

   // Pin inputs, after synchronisation
   logic isa_mode_s;
   logic jumperless_s;
   logic group_sel_n_s;
   logic [4:0] sa_s;
   logic ior_n_s;
   logic iow_n_s;
   logic [7:0] sd_s;
   logic ee_do_s;
   // Strobes and window select are synchronised active high, so a cleared stage reads idle
   logic group_sel_s;
   logic ior_s;
   logic iow_s;

   // Strobe history and captured cycle
   logic ior_n_d_ff;
   logic iow_n_d_ff;
   logic read_start;
   logic write_end;
   logic [4:0] wr_addr_ff;
   logic [7:0] wr_data_ff;
   logic wr_hit_ff;
   logic group_hit;

   // Decoded accesses
   logic rd_pin_control;
   logic rd_serial_data;
   logic rd_base_advance;
   logic rd_jumperless;
   logic rd_reserved;
   logic wr_pin_control;
   logic wr_serial_data;
   logic [aux_regs_pkg::SOFT_RESET_PORTS-1:0] wr_reset_port;
   logic soft_reset_req;

   // Register state
   logic shift_clock_ff;
   logic select_ff;
   logic serial_io_ff;
   logic [7:0] rd_data_ff;
   logic sd_oe_ff;
   logic [2:0] base_sel;
   logic [1:0] int_sel_ff;
   logic [2:0] soft_cnt_ff;
   logic soft_reset_ff;
   logic [7:0] nxt_rd_data;

   pin_sync #(
      .WIDTH(PIN_W)
   ) u_pin_sync (
      .clk(CLK_SYS),
      .rst_n(RESET_N),
      .async_in({ISA_MODE, JUMPERLESS_MODE, ~GROUP_SEL_N, SA, ~IOR_N, ~IOW_N, SD_IN, EE_DO}),
      .sync_out({isa_mode_s, jumperless_s, group_sel_s, sa_s, ior_s, iow_s, sd_s, ee_do_s})
   );

   assign group_sel_n_s = ~group_sel_s;
   assign ior_n_s = ~ior_s;
   assign iow_n_s = ~iow_s;

   // Strobe edges are taken from the synchronised copies only
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         ior_n_d_ff <= 1'b1;
         iow_n_d_ff <= 1'b1;
      end else begin
         ior_n_d_ff <= ior_n_s;
         iow_n_d_ff <= iow_n_s;
      end
   end

   assign read_start = ior_n_d_ff & ~ior_n_s;
   assign write_end = ~iow_n_d_ff & iow_n_s;

   // Upper group bit plus the external window select; bank select is never looked at
   assign group_hit = isa_mode_s & ~group_sel_n_s & sa_s[4];

   // Address and data are sampled through the strobe and used at its rising edge,
   // so no hold time after the strobe is needed on the pins
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         wr_addr_ff <= '0;
         wr_data_ff <= '0;
         wr_hit_ff <= 1'b0;
      end else if (!iow_n_s) begin
         wr_addr_ff <= sa_s;
         wr_data_ff <= sd_s;
         wr_hit_ff <= group_hit;
      end
   end

   assign rd_pin_control = read_start & group_hit &
                           (sa_s == aux_regs_pkg::OFS_EEPROM_PIN_CONTROL);
   assign rd_serial_data = read_start & group_hit &
                           (sa_s == aux_regs_pkg::OFS_EEPROM_SERIAL_DATA);
   assign rd_base_advance = read_start & group_hit &
                            (sa_s == aux_regs_pkg::OFS_IO_BASE_ADVANCE);
   assign rd_jumperless = read_start & group_hit &
                          (sa_s == aux_regs_pkg::OFS_JUMPERLESS_SETTING);
   assign rd_reserved = read_start & group_hit &
                        (sa_s[4:2] == aux_regs_pkg::OFS_RESERVED_FIRST[4:2]);
   assign wr_pin_control = write_end & wr_hit_ff &
                           (wr_addr_ff == aux_regs_pkg::OFS_EEPROM_PIN_CONTROL);
   assign wr_serial_data = write_end & wr_hit_ff &
                           (wr_addr_ff == aux_regs_pkg::OFS_EEPROM_SERIAL_DATA);

   // One decode per reset port; any data value triggers
   for (genvar i = 0; i < aux_regs_pkg::SOFT_RESET_PORTS; i++) begin : g_reset_port
      assign wr_reset_port[i] = write_end & wr_hit_ff &
         (wr_addr_ff == (aux_regs_pkg::OFS_SOFT_RESET_FIRST + 5'(i)));
   end

   assign soft_reset_req = |wr_reset_port;

   // EEPROM port bits are cleared only by the hardware reset; soft reset leaves them
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         shift_clock_ff <= aux_regs_pkg::EEPROM_SHIFT_CLOCK_RST;
      end else if (wr_pin_control) begin
         // Unused bits are ignored, whatever software writes there
         shift_clock_ff <= wr_data_ff[aux_regs_pkg::EEPROM_SHIFT_CLOCK_BIT];
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         select_ff <= aux_regs_pkg::EEPROM_SELECT_RST;
      end else if (wr_pin_control) begin
         select_ff <= wr_data_ff[aux_regs_pkg::EEPROM_SELECT_BIT];
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         serial_io_ff <= aux_regs_pkg::EEPROM_SERIAL_IO_RST;
      end else if (wr_serial_data) begin
         serial_io_ff <= wr_data_ff[aux_regs_pkg::EEPROM_SERIAL_IO_BIT];
      end
   end

   // Pins are driven from output flops that follow the port flops one cycle later
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         EE_SK <= aux_regs_pkg::EEPROM_SHIFT_CLOCK_RST;
      end else begin
         EE_SK <= shift_clock_ff;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         EE_CS <= aux_regs_pkg::EEPROM_SELECT_RST;
      end else begin
         EE_CS <= select_ff;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         EE_DI <= aux_regs_pkg::EEPROM_SERIAL_IO_RST;
      end else begin
         EE_DI <= serial_io_ff;
      end
   end

   base_select_counter u_base_select_counter (
      .clk(CLK_SYS),
      .rst_n(RESET_N),
      .soft_clear(soft_reset_ff),
      .load(BOOT_LOAD),
      .load_value(BOOT_BASE_SEL),
      .advance_req(rd_base_advance),
      .jumperless(jumperless_s),
      .unlock(IO_BASE_UNLOCK),
      .sel_ff(base_sel)
   );

   // Interrupt channel field comes from the boot load only
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         int_sel_ff <= '0;
      end else if (soft_reset_ff) begin
         int_sel_ff <= '0;
      end else if (BOOT_LOAD) begin
         int_sel_ff <= BOOT_INT_SEL;
      end
   end

   // Read mux; undefined bits are returned as zero
   always_comb begin
      nxt_rd_data = aux_regs_pkg::READ_DATA_RST;
      if (rd_serial_data) begin
         nxt_rd_data[aux_regs_pkg::EEPROM_SERIAL_IO_BIT] = ee_do_s;
      end else if (rd_base_advance) begin
         nxt_rd_data = aux_regs_pkg::BASE_ADVANCE_READ_VALUE;
      end else if (rd_jumperless) begin
         nxt_rd_data[aux_regs_pkg::BASE_SEL_LSB +: aux_regs_pkg::SEL_W] = base_sel;
         nxt_rd_data[aux_regs_pkg::INT_SEL_LSB +: aux_regs_pkg::INT_W] = int_sel_ff;
      end else if (rd_pin_control) begin
         nxt_rd_data = aux_regs_pkg::READ_DATA_RST;
      end else if (rd_reserved) begin
         nxt_rd_data = aux_regs_pkg::READ_DATA_RST;
      end
   end

   // Read data is latched at the strobe's start and held for the whole strobe
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         rd_data_ff <= aux_regs_pkg::READ_DATA_RST;
      end else if (read_start) begin
         rd_data_ff <= nxt_rd_data;
      end
   end

   // Data bus is driven only while a read of this group is in progress
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         sd_oe_ff <= 1'b0;
      end else if (ior_n_s) begin
         sd_oe_ff <= 1'b0;
      end else if (read_start) begin
         sd_oe_ff <= group_hit;
      end
   end

   assign SD_OUT = rd_data_ff;
   assign SD_OE = sd_oe_ff;

   // Soft reset pulse, stretched so the slowest block downstream sees it
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         soft_cnt_ff <= '0;
      end else if (soft_reset_req) begin
         soft_cnt_ff <= 3'(aux_regs_pkg::SOFT_RESET_CYCLES - 1);
      end else if (soft_cnt_ff != 3'h0) begin
         soft_cnt_ff <= soft_cnt_ff - 3'h1;
      end
   end

   // Pulse stays high while the count runs and drops once it has reached zero
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         soft_reset_ff <= 1'b0;
      end else if (soft_reset_req) begin
         soft_reset_ff <= 1'b1;
      end else if (soft_cnt_ff == 3'h0) begin
         soft_reset_ff <= 1'b0;
      end
   end

   // Active base decode select for the address comparator outside
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         BASE_SEL <= aux_regs_pkg::BASE_SEL_RST;
      end else begin
         BASE_SEL <= base_sel;
      end
   end

   assign SOFT_RESET = soft_reset_ff;
endmodule : isa_aux_eeprom_iobase_regs
`default_nettype wire

// *** testbench/aux_regs_asserts.sv ***
// Concurrent checks on the auxiliary register group ports
`default_nettype none
module aux_regs_asserts (
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic IOR_N,
   input wire logic IOW_N,
   input wire logic SD_OE,
   input wire logic IO_BASE_UNLOCK,
   input wire logic BOOT_LOAD,
   input wire logic [2:0] BASE_SEL,
   input wire logic EE_SK,
   input wire logic EE_CS,
   input wire logic EE_DI,
   input wire logic SOFT_RESET
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wr_age_ff;
   logic [3:0] rd_age_ff;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);
   // Ages saturate, so a change long after any strobe still fails
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) wr_age_ff <= 4'hf;
      else if (!IOW_N) wr_age_ff <= 4'h0;
      else if (wr_age_ff != 4'hf) wr_age_ff <= wr_age_ff + 4'h1;
   end
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) rd_age_ff <= 4'hf;
      else if (!IOR_N) rd_age_ff <= 4'h0;
      else if (rd_age_ff != 4'hf) rd_age_ff <= rd_age_ff + 4'h1;
   end
   chk_oe_cause: assert property (SD_OE |->
      !$past(IOR_N, 2) || !$past(IOR_N, 3) || !$past(IOR_N, 4))
      else $error("read data driven without a read strobe");
   chk_oe_release: assert property ($rose(IOR_N) |-> ##5 !SD_OE)
      else $error("read data still driven after strobe end");
   chk_pins_cause: assert property ($changed({EE_SK, EE_CS, EE_DI}) |-> wr_age_ff <= 4'ha)
      else $error("eeprom pin moved without a write");
   chk_soft_width: assert property ($rose(SOFT_RESET) |-> SOFT_RESET [*4] ##1 !SOFT_RESET)
      else $error("soft reset pulse length wrong");
   chk_soft_cause: assert property ($rose(SOFT_RESET) |-> wr_age_ff <= 4'ha)
      else $error("soft reset without a write");
   chk_base_clear: assert property ($fell(SOFT_RESET) |-> BASE_SEL == 3'h0)
      else $error("base select not cleared by soft reset");
   chk_base_step: assert property ($changed(BASE_SEL) |->
      BASE_SEL == 3'($past(BASE_SEL) + 3'h1) || BASE_SEL == 3'h0 ||
      $past(BOOT_LOAD, 1) || $past(BOOT_LOAD, 2) || $past(BOOT_LOAD, 3))
      else $error("base select jumped");
   chk_base_cause: assert property ($changed(BASE_SEL) &&
      BASE_SEL == 3'($past(BASE_SEL) + 3'h1) && !$past(BOOT_LOAD, 1) &&
      !$past(BOOT_LOAD, 2) && !$past(BOOT_LOAD, 3) && !$past(SOFT_RESET, 1) |->
      rd_age_ff <= 4'h8 &&
      ($past(IO_BASE_UNLOCK, 2) || $past(IO_BASE_UNLOCK, 3) || $past(IO_BASE_UNLOCK, 4)))
      else $error("base select advanced without an unlocked read");
endmodule : aux_regs_asserts
`default_nettype wire

// *** testbench/eeprom_model.sv ***
// Behavioural serial EEPROM on its clock, select and data pins
`default_nettype none
module eeprom_model (
   input wire logic sk,
   input wire logic cs,
   input wire logic di,
   output logic do_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sreg_ff = 8'h5a;
   logic idle_ff = 1'b0;
   always @(posedge sk) if (cs) sreg_ff <= {sreg_ff[6:0], di};
   // Deselected output flips so a stale level never passes for data
   always @(negedge cs) idle_ff <= ~sreg_ff[7];
   assign do_out = cs ? sreg_ff[7] : idle_ff;
endmodule : eeprom_model
`default_nettype wire

// *** testbench/isa_aux_eeprom_iobase_regs_bench.sv ***
// Self-checking bench for the ISA auxiliary register group
`default_nettype none
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin n_mismatch++; \
   $display("Error at %0t: got %h expected %h", $time, act, exp); end end
module isa_aux_eeprom_iobase_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK_SYS = 1'b0, RESET_N = 1'b0, ISA_MODE = 1'b1, JUMPERLESS_MODE = 1'b1;
   logic GROUP_SEL_N = 1'b1, IOR_N = 1'b1, IOW_N = 1'b1, IO_BASE_UNLOCK = 1'b1;
   logic BOOT_LOAD = 1'b0, EE_DO, SD_OE, EE_SK, EE_CS, EE_DI, SOFT_RESET, oe_q = 1'b0;
   logic [4:0] SA = 5'h00;
   logic [7:0] SD_IN = 8'h00, SD_OUT, v;
   logic [2:0] BOOT_BASE_SEL = 3'h0, BASE_SEL, sel;
   logic [1:0] BOOT_INT_SEL = 2'h0;
   logic [15:0] expq[$];
   int n_mismatch = 0;
   int check_count = 0;
   always #5 CLK_SYS = ~CLK_SYS;
   isa_aux_eeprom_iobase_regs u_dut (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
      .ISA_MODE(ISA_MODE), .JUMPERLESS_MODE(JUMPERLESS_MODE), .GROUP_SEL_N(GROUP_SEL_N),
      .SA(SA), .IOR_N(IOR_N), .IOW_N(IOW_N), .SD_IN(SD_IN), .SD_OUT(SD_OUT), .SD_OE(SD_OE),
      .IO_BASE_UNLOCK(IO_BASE_UNLOCK), .BOOT_LOAD(BOOT_LOAD), .BOOT_BASE_SEL(BOOT_BASE_SEL),
      .BOOT_INT_SEL(BOOT_INT_SEL), .BASE_SEL(BASE_SEL), .EE_SK(EE_SK), .EE_CS(EE_CS),
      .EE_DI(EE_DI), .EE_DO(EE_DO), .SOFT_RESET(SOFT_RESET));
   eeprom_model u_rom (.sk(EE_SK), .cs(EE_CS), .di(EE_DI), .do_out(EE_DO));
   // Each answer is judged once, at the falling edge after the bus is first driven,
   // so the value is settled rather than racing the launching edge
   always @(negedge CLK_SYS) begin
      oe_q <= SD_OE;
      if (SD_OE === 1'b1 && oe_q !== 1'b1) begin
         if (expq.size() == 0) `CHK(SD_OE, 1'b0)
         else begin
            `CHK(SD_OUT & expq[0][15:8], expq[0][7:0])
            void'(expq.pop_front());
         end
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   // Strobe held 6 cycles, then 8 idle cycles so the synchronised strobe settles
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
      input logic gn);
      @(posedge CLK_SYS);
      SA <= a;
      SD_IN <= d;
      GROUP_SEL_N <= gn;
      if (wr) IOW_N <= 1'b0;
      else IOR_N <= 1'b0;
      repeat (6) @(posedge CLK_SYS);
      IOW_N <= 1'b1;
      IOR_N <= 1'b1;
      repeat (8) @(posedge CLK_SYS);
      GROUP_SEL_N <= 1'b1;
   endtask : bus
   task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
      expq.push_back({m, e});
      bus(1'b0, a, 8'h00, 1'b0);
      for (int i = 0; i < 20 && expq.size() != 0; i++) @(posedge CLK_SYS);
      `CHK(expq.size(), 0)
      if (expq.size() != 0) summarize();
   endtask : rd
   initial begin
      void'($urandom(81));
      repeat (5) @(posedge CLK_SYS);
      RESET_N <= 1'b1;
      repeat (4) @(posedge CLK_SYS);
      rd(5'h13, 8'hff, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         v = 8'($urandom());
         bus(1'b1, 5'h10, v & 8'h60, 1'b0);
         `CHK({EE_SK, EE_CS}, v[6:5])
         bus(1'b1, 5'h11, v & 8'h80, 1'b0);
         `CHK({EE_DI, EE_SK, EE_CS}, v[7:5])
         rd(5'h11, 8'h80, {EE_DO, 7'h00});
         rd(5'h10, 8'h00, 8'h00);
      end
      $display("test eeprom done");
      sel = 3'h0;
      for (int i = 0; i < 9; i++) begin
         rd(5'h12, 8'h00, 8'h00);
         sel = sel + 3'h1;
         rd(5'h13, 8'h07, {5'h00, sel});
         `CHK(BASE_SEL, sel)
      end
      IO_BASE_UNLOCK <= 1'b0;
      rd(5'h12, 8'h00, 8'h00);
      rd(5'h13, 8'h07, {5'h00, sel});
      IO_BASE_UNLOCK <= 1'b1;
      JUMPERLESS_MODE <= 1'b0;
      rd(5'h12, 8'h00, 8'h00);
      rd(5'h13, 8'h07, {5'h00, sel});
      JUMPERLESS_MODE <= 1'b1;
      $display("test base advance done");
      bus(1'b0, 5'h13, 8'h00, 1'b1);
      bus(1'b0, 5'h03, 8'h00, 1'b0);
      bus(1'b1, 5'h00, 8'h60 & ~v, 1'b0);
      ISA_MODE <= 1'b0;
      bus(1'b1, 5'h10, 8'h60 & ~v, 1'b0);
      bus(1'b0, 5'h13, 8'h00, 1'b0);
      `CHK({EE_DI, EE_SK, EE_CS}, v[7:5])
      ISA_MODE <= 1'b1;
      rd(5'h14 | 5'($urandom_range(3)), 8'hff, 8'h00);
      $display("test refusal done");
      for (int p = 0; p < 8; p++) begin
         @(posedge CLK_SYS);
         BOOT_BASE_SEL <= 3'($urandom());
         BOOT_INT_SEL <= 2'($urandom());
         BOOT_LOAD <= 1'b1;
         @(posedge CLK_SYS);
         BOOT_LOAD <= 1'b0;
         rd(5'h13, 8'hc7, {BOOT_INT_SEL, 3'h0, BOOT_BASE_SEL});
         bus(1'b1, 5'h18 + 5'(p), 8'($urandom()), 1'b0);
         rd(5'h13, 8'hc7, 8'h00);
         `CHK({EE_DI, EE_SK, EE_CS}, v[7:5])
      end
      RESET_N <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      RESET_N <= 1'b1;
      repeat (4) @(posedge CLK_SYS);
      `CHK({EE_DI, EE_SK, EE_CS, BASE_SEL}, 6'h00)
      $display("test soft reset done");
      summarize();
   end
endmodule : isa_aux_eeprom_iobase_regs_bench
bind isa_aux_eeprom_iobase_regs aux_regs_asserts u_chk (.CLK_SYS(CLK_SYS),
   .RESET_N(RESET_N), .IOR_N(IOR_N), .IOW_N(IOW_N), .SD_OE(SD_OE),
   .IO_BASE_UNLOCK(IO_BASE_UNLOCK), .BOOT_LOAD(BOOT_LOAD), .BASE_SEL(BASE_SEL),
   .EE_SK(EE_SK), .EE_CS(EE_CS), .EE_DI(EE_DI), .SOFT_RESET(SOFT_RESET));
`default_nettype wire
